// ==== logic/fms_regs.vh ====
`ifndef FMS_REGS_VH
`define FMS_REGS_VH

// Core clock rate in MHz
`define FMS_CLK_MHZ 100
// Serial word layout, MSB first
`define FMS_WORD_BITS 16
`define FMS_CNT_W 4
`define FMS_WD_BIT 15
// Device status word (number seven) field positions
`define FMS_ST_LINK_FAULT 15
`define FMS_ST_FAIL_PIN 14
`define FMS_ST_FAULT_LSB 6
`define FMS_FAULT_W 8
// Watchdog timeout in ms for the two selections
`define FMS_WD_SHORT_MS 32
`define FMS_WD_LONG_MS 128
// Fail input deglitch time in us
`define FMS_DGL_US 200
// Derived cycle counts
`define FMS_WD_SHORT_CYC (`FMS_WD_SHORT_MS * 1000 * `FMS_CLK_MHZ)
`define FMS_WD_LONG_CYC (`FMS_WD_LONG_MS * 1000 * `FMS_CLK_MHZ)
`define FMS_DGL_CYC (`FMS_DGL_US * `FMS_CLK_MHZ)
// Channel counts
`define FMS_N_POWER 5
`define FMS_N_DIRECT 4

`endif

// ==== logic/fms_supervisor.v ====
// Contract
// - Both supplies lost: all off, all cleared
// - Battery lost: keep state, outputs 1-5 off
// - No wake report during battery loss
// - Logic supply lost acts as watchdog timeout
// - Normal mode: outputs follow PWM engine
// - Fault reports readable over serial port
// - Direct inputs only steer outputs in fail
// - Fail input high forces fail mode
// - Fail mode: outputs 1-4 follow direct inputs, output 5 off
// - Fail input level shown in status seven
// - Any serial error forces fail mode
// - Watchdog bit must toggle every word
// - Watchdog timeout without message is error
// - Frame bit count must be multiple of 16
// - Stuck input caught by toggle check only
// - Error sets link fault flag, reported next
// - Link fault flag held throughout fail mode
// - Flag cleared on fail to normal transition
// - Fail input deglitched, 200 us high
`timescale 1ns/1ns
`default_nettype none
`include "fms_regs.vh"

module fms_supervisor #(
  parameter integer WD_SHORT_CYC = `FMS_WD_SHORT_CYC,
  parameter integer WD_LONG_CYC = `FMS_WD_LONG_CYC,
  parameter integer DGL_CYC = `FMS_DGL_CYC
) (
  input wire core_clk,
  input wire srst,
  input wire vbat_ok,
  input wire vcc_ok,
  input wire wake_state,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output wire spi_miso_oe,
  input wire fail_mode_pin,
  input wire [`FMS_N_DIRECT-1:0] direct_channel_inputs,
  input wire [`FMS_N_POWER:0] pwm_channel_drive,
  input wire [`FMS_FAULT_W-1:0] fault_reports,
  input wire wd_timeout_sel,
  output reg [`FMS_N_POWER-1:0] power_output_channels,
  output reg external_switch_control_output,
  output reg wake_report,
  output reg [`FMS_WORD_BITS-1:0] rx_word,
  output reg rx_word_valid,
  output reg fail_mode,
  output reg serial_link_fault_flag,
  output reg filtered_fail_request
);

  localparam [2:0] ST_NORMAL = 3'h1;
  localparam [2:0] ST_FAIL = 3'h2;
  localparam [2:0] ST_OFF = 3'h4;
  localparam integer NS = 6 + `FMS_N_DIRECT;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the supply, serial, fail and direct input pins

  reg [NS-1:0] sync1;
  reg [NS-1:0] sync2;
  always @(posedge core_clk) begin
    if (srst) begin
      sync1 <= {NS{1'b0}};
      sync2 <= {NS{1'b0}};
    end else begin
      sync1 <= {direct_channel_inputs, fail_mode_pin, spi_mosi, spi_cs_n, spi_clk,
                vcc_ok, vbat_ok};
      sync2 <= sync1;
    end
  end

  wire vbat_s = sync2[0];
  wire vcc_s = sync2[1];
  wire sclk_s = sync2[2];
  wire cs_n_s = sync2[3];
  wire mosi_s = sync2[4];
  wire fail_pin_s = sync2[5];
  wire [`FMS_N_DIRECT-1:0] din_s = sync2[NS-1:6];

  // Both rails below reset level wipes all state like a reset
  wire power_off = !vbat_s && !vcc_s;
  wire rst_i = srst || power_off;

  ////////////////////////////////////////////////////////////////////////////
  // Fail input deglitch, symmetric

  reg [15:0] dgl_cnt;
  always @(posedge core_clk) begin
    if (rst_i) begin
      dgl_cnt <= 16'h0000;
      filtered_fail_request <= 1'b0;
    end else if (fail_pin_s == filtered_fail_request) begin
      dgl_cnt <= 16'h0000;
    end else if (dgl_cnt == DGL_CYC[15:0] - 16'h0001) begin
      dgl_cnt <= 16'h0000;
      filtered_fail_request <= fail_pin_s;
    end else begin
      dgl_cnt <= dgl_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and transmit

  reg sclk_d;
  reg cs_n_d;
  always @(posedge core_clk) begin
    if (rst_i) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  // A dead logic rail leaves the port unusable, so frames are ignored
  wire link_up = vcc_s;
  wire cs_fall = link_up && cs_n_d && !cs_n_s;
  wire cs_rise = link_up && !cs_n_d && cs_n_s;
  wire sclk_rise = link_up && !cs_n_s && !sclk_d && sclk_s;
  wire sclk_fall = link_up && !cs_n_s && sclk_d && !sclk_s;

  reg [`FMS_WORD_BITS-1:0] rx_shift;
  reg [`FMS_WORD_BITS-1:0] tx_shift;
  reg [`FMS_CNT_W-1:0] bit_cnt;
  reg last_wd;
  reg frame_has_word;
  reg frame_bad;
  reg toggle_err;
  reg length_err;
  reg good_frame;

  wire word_end = sclk_rise && (bit_cnt == {`FMS_CNT_W{1'b1}});
  wire [`FMS_WORD_BITS-1:0] word_in = {rx_shift[`FMS_WORD_BITS-2:0], mosi_s};
  // A stuck data line repeats the same bit, which the toggle check catches
  wire wd_rx = word_in[`FMS_WD_BIT];
  wire wd_same = (wd_rx == last_wd);

  // Status word seven, snapshot at frame start so errors show next frame
  wire [`FMS_WORD_BITS-1:0] status_word =
    ({{(`FMS_WORD_BITS-1){1'b0}}, serial_link_fault_flag} << `FMS_ST_LINK_FAULT) |
    ({{(`FMS_WORD_BITS-1){1'b0}}, fail_pin_s} << `FMS_ST_FAIL_PIN) |
    ({{(`FMS_WORD_BITS-`FMS_FAULT_W){1'b0}}, fault_reports} << `FMS_ST_FAULT_LSB);

  always @(posedge core_clk) begin
    if (rst_i) begin
      rx_shift <= {`FMS_WORD_BITS{1'b0}};
      tx_shift <= {`FMS_WORD_BITS{1'b0}};
      bit_cnt <= {`FMS_CNT_W{1'b0}};
      last_wd <= 1'b0;
      frame_has_word <= 1'b0;
      frame_bad <= 1'b0;
      toggle_err <= 1'b0;
      length_err <= 1'b0;
      good_frame <= 1'b0;
      rx_word <= {`FMS_WORD_BITS{1'b0}};
      rx_word_valid <= 1'b0;
      spi_miso <= 1'b0;
    end else begin
      toggle_err <= 1'b0;
      length_err <= 1'b0;
      good_frame <= 1'b0;
      rx_word_valid <= 1'b0;
      if (cs_fall) begin
        bit_cnt <= {`FMS_CNT_W{1'b0}};
        frame_has_word <= 1'b0;
        frame_bad <= 1'b0;
        tx_shift <= status_word;
        spi_miso <= status_word[`FMS_WORD_BITS-1];
      end
      if (sclk_rise) begin
        rx_shift <= word_in;
        bit_cnt <= bit_cnt + {{(`FMS_CNT_W-1){1'b0}}, 1'b1};
      end
      if (word_end) begin
        last_wd <= wd_rx;
        frame_has_word <= 1'b1;
        if (wd_same) begin
          toggle_err <= 1'b1;
          frame_bad <= 1'b1;
        end else begin
          rx_word <= word_in;
          rx_word_valid <= 1'b1;
        end
      end
      if (sclk_fall) begin
        // Daisy chain: data in falls through behind the status bits
        tx_shift <= {tx_shift[`FMS_WORD_BITS-2:0], rx_shift[`FMS_WORD_BITS-1]};
        spi_miso <= tx_shift[`FMS_WORD_BITS-2];
      end
      if (cs_rise) begin
        if (bit_cnt != {`FMS_CNT_W{1'b0}}) begin
          length_err <= 1'b1;
        end else if (frame_has_word && !frame_bad) begin
          good_frame <= 1'b1;
        end
      end
    end
  end

  assign spi_miso_oe = link_up && !cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog timer

  reg [23:0] wd_cnt;
  reg wd_timeout;
  wire [23:0] wd_limit = wd_timeout_sel ? WD_LONG_CYC[23:0] : WD_SHORT_CYC[23:0];
  always @(posedge core_clk) begin
    if (rst_i) begin
      wd_cnt <= 24'h000000;
      wd_timeout <= 1'b0;
    end else begin
      wd_timeout <= 1'b0;
      if (good_frame) begin
        wd_cnt <= 24'h000000;
      end else if (!vcc_s || wd_cnt == wd_limit - 24'h000001) begin
        // Lost logic rail expires the timer at once
        wd_cnt <= 24'h000000;
        wd_timeout <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 24'h000001;
      end
    end
  end

  wire comm_err = toggle_err || length_err || wd_timeout;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine and link fault flag

  reg [2:0] state;
  reg [2:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (filtered_fail_request || comm_err) begin
          next_state = ST_FAIL;
        end
      end
      ST_FAIL: begin
        // Leave once the pin request is gone, on a clean frame if the link fault flag is set
        if (!filtered_fail_request && !comm_err &&
            (good_frame || !serial_link_fault_flag)) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst_i) begin
      state <= ST_NORMAL;
      fail_mode <= 1'b0;
      serial_link_fault_flag <= 1'b0;
    end else begin
      state <= next_state;
      fail_mode <= (next_state == ST_FAIL);
      if (comm_err) begin
        serial_link_fault_flag <= 1'b1;
      end else if (state == ST_FAIL && next_state == ST_NORMAL) begin
        serial_link_fault_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing

  always @(posedge core_clk) begin
    if (rst_i) begin
      power_output_channels <= {`FMS_N_POWER{1'b0}};
      external_switch_control_output <= 1'b0;
      wake_report <= 1'b0;
    end else begin
      wake_report <= wake_state && vbat_s;
      if (!vbat_s) begin
        power_output_channels <= {`FMS_N_POWER{1'b0}};
      end else if (state == ST_FAIL) begin
        power_output_channels <= {1'b0, din_s};
      end else begin
        power_output_channels <= pwm_channel_drive[`FMS_N_POWER-1:0];
      end
      // External switch is held low in fail mode, kept on battery loss
      external_switch_control_output <= (state == ST_NORMAL) &&
                                        pwm_channel_drive[`FMS_N_POWER];
    end
  end

endmodule // fms_supervisor

`default_nettype wire

// ==== test/fms_props_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fms_regs.vh"
module fms_props #(parameter integer WD_LONG_CYC = 4000, parameter integer DGL_CYC = 20) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic vbat_ok,
  input wire logic fail_mode_pin,
  input wire logic [`FMS_N_DIRECT-1:0] direct_channel_inputs,
  input wire logic [`FMS_N_POWER:0] pwm_channel_drive,
  input wire logic [`FMS_N_POWER-1:0] power_output_channels,
  input wire logic external_switch_control_output,
  input wire logic wake_report,
  input wire logic rx_word_valid,
  input wire logic fail_mode,
  input wire logic serial_link_fault_flag,
  input wire logic filtered_fail_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [23:0] idle_cnt;
  logic [15:0] high_cnt;
  // Idle span in normal mode; loose bound since watchdog restarts at frame end
  always_ff @(posedge core_clk) begin
    idle_cnt <= (srst || fail_mode || rx_word_valid) ? 24'h0 : idle_cnt + 24'h1;
    high_cnt <= (srst || !fail_mode_pin) ? 16'h0 : high_cnt + 16'h1;
  end
  a_bat_loss_off: assert property (!vbat_ok [*4] |-> power_output_channels == 5'h00)
    else $error("outputs on without battery");
  a_wake_masked: assert property (!vbat_ok [*4] |-> !wake_report)
    else $error("wake shown without battery");
  a_fail_direct: assert property (
    (fail_mode && vbat_ok && $stable(direct_channel_inputs)) [*5]
    |-> power_output_channels == {1'b0, direct_channel_inputs})
    else $error("fail outputs differ from inputs");
  a_normal_pwm: assert property (
    (!fail_mode && vbat_ok && $stable(pwm_channel_drive)) [*5]
    |-> power_output_channels == pwm_channel_drive[4:0])
    else $error("normal outputs differ from pwm");
  a_ext_off_fail: assert property (fail_mode [*2] |-> !external_switch_control_output)
    else $error("external switch on in fail");
  a_flag_held: assert property (
    serial_link_fault_flag && fail_mode |=> serial_link_fault_flag || !fail_mode)
    else $error("flag lost in fail");
  a_flag_drop: assert property ($fell(fail_mode) |-> !serial_link_fault_flag)
    else $error("flag kept after fail exit");
  a_flag_in_fail: assert property (serial_link_fault_flag |-> fail_mode)
    else $error("flag without fail mode");
  a_wd_bound: assert property (idle_cnt <= WD_LONG_CYC + 64)
    else $error("watchdog did not expire");
  a_pin_deglitch: assert property ($rose(filtered_fail_request) |-> high_cnt >= DGL_CYC)
    else $error("fail request too early");
  a_pin_fails: assert property (filtered_fail_request |=> fail_mode)
    else $error("fail request ignored");
  c_link_err: cover property ($rose(serial_link_fault_flag));
  c_pin_fail: cover property ($rose(filtered_fail_request));
  c_good_word: cover property (rx_word_valid);
endmodule // fms_props
bind fms_supervisor fms_props #(.WD_LONG_CYC(WD_LONG_CYC), .DGL_CYC(DGL_CYC)) u_props (
  .core_clk, .srst, .vbat_ok, .fail_mode_pin, .direct_channel_inputs, .pwm_channel_drive,
  .power_output_channels, .external_switch_control_output, .wake_report, .rx_word_valid,
  .fail_mode, .serial_link_fault_flag, .filtered_fail_request
);
`default_nettype wire

// ==== test/fms_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module fms_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Link clock stands low outside frames
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Odd offset keeps link edges off the core clock edges
  task automatic cs(input logic lvl);
    #243 spi_cs_n = lvl;
    if (lvl) spi_mosi = ~spi_mosi;
    #240;
  endtask
  // One bit of a 160 ns period, read back on the rise
  task automatic bit1(input logic b, output logic r);
    spi_mosi = b;
    #80 spi_clk = 1'b1;
    r = spi_miso;
    #80 spi_clk = 1'b0;
  endtask
  // Whole word, MSB first
  task automatic word(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) bit1(w[i], r[i]);
  endtask
endmodule // fms_host
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fms_regs.vh"
module testbench;
  logic core_clk = 1'b0, srst = 1'b1, vbat_ok = 1'b1, vcc_ok = 1'b1, wake_state = 1'b0;
  logic fail_mode_pin = 1'b0, wd_timeout_sel = 1'b0, wd = 1'b0;
  logic [3:0] direct_channel_inputs = 4'h0, tick = 4'h0;
  logic [5:0] pwm_channel_drive = 6'h00;
  logic [7:0] fault_reports = 8'h00;
  logic [15:0] w, st;
  wire [15:0] rx_word;
  wire [4:0] power_output_channels;
  wire spi_clk, spi_cs_n, spi_mosi, spi_miso, external_switch_control_output, wake_report;
  wire rx_word_valid, fail_mode, serial_link_fault_flag, filtered_fail_request;
  wire spi_miso_oe;
  integer seed = 66, num_errors = 0, compares = 0;
  fms_supervisor #(.WD_SHORT_CYC(2000), .WD_LONG_CYC(4000), .DGL_CYC(20)) dut (
    .core_clk, .srst, .vbat_ok, .vcc_ok, .wake_state, .spi_clk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe, .fail_mode_pin, .direct_channel_inputs, .pwm_channel_drive,
    .fault_reports, .wd_timeout_sel, .power_output_channels, .external_switch_control_output,
    .wake_report, .rx_word, .rx_word_valid, .fail_mode, .serial_link_fault_flag,
    .filtered_fail_request
  );
  fms_host host (.spi_clk, .spi_cs_n, .spi_mosi, .spi_miso);
  initial forever #5 core_clk = ~core_clk;
  // New levels every 16 cycles so outputs settle between changes
  always @(negedge core_clk) begin
    tick <= tick + 4'h1;
    if (tick == 4'h0) begin
      pwm_channel_drive <= 6'($random(seed));
      direct_channel_inputs <= 4'($random(seed));
      wake_state <= 1'($random(seed));
    end
  end
  task automatic test_done;
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Mid-way between random changes
  task automatic settle;
    while (tick != 4'h8) @(negedge core_clk);
  endtask
  function automatic logic [15:0] exp_st(input logic f, input logic p);
    return {f, p, fault_reports, 6'h00};
  endfunction
  // One word frame; flip 0 repeats the watchdog bit, extra adds a 17th bit
  task automatic frame(input logic flip, input logic extra);
    logic b;
    wd ^= flip;
    w = {wd, 15'($random(seed))};
    fault_reports = 8'($random(seed));
    host.cs(1'b0);
    chk(spi_miso_oe, 1'b1);
    host.word(w, st);
    if (extra) host.bit1(1'b0, b);
    host.cs(1'b1);
    chk(spi_miso_oe, 1'b0);
    cyc(4);
  endtask
  initial begin
    #400000;
    num_errors++;
    test_done;
  end
  initial begin
    cyc(4);
    srst = 1'b0;
    cyc(3);
    repeat (4) begin
      frame(1'b1, 1'b0);
      chk(st, exp_st(1'b0, 1'b0));
      chk(rx_word, w);
    end
    settle;
    chk(power_output_channels, pwm_channel_drive[4:0]);
    chk(external_switch_control_output, pwm_channel_drive[5]);
    chk(wake_report, wake_state);
    frame(1'b0, 1'b0);
    chk(serial_link_fault_flag, 1'b1);
    settle;
    chk(power_output_channels, {1'b0, direct_channel_inputs});
    chk(external_switch_control_output, 1'b0);
    frame(1'b1, 1'b0);
    chk(st, exp_st(1'b1, 1'b0));
    chk(fail_mode, 1'b0);
    chk(serial_link_fault_flag, 1'b0);
    frame(1'b1, 1'b1);
    chk(fail_mode, 1'b1);
    frame(1'b1, 1'b0);
    for (int s = 0; s < 2; s++) begin
      wd_timeout_sel = s[0];
      frame(1'b1, 1'b0);
      cyc(s ? 3900 : 1900);
      chk(fail_mode, 1'b0);
      cyc(300);
      chk(serial_link_fault_flag, 1'b1);
      frame(1'b1, 1'b0);
    end
    fail_mode_pin = 1'b1;
    cyc(10);
    fail_mode_pin = 1'b0;
    cyc(40);
    chk(fail_mode, 1'b0);
    fail_mode_pin = 1'b1;
    cyc(40);
    frame(1'b1, 1'b0);
    chk(st, exp_st(1'b0, 1'b1));
    chk(fail_mode, 1'b1);
    fail_mode_pin = 1'b0;
    cyc(40);
    chk(fail_mode, 1'b0);
    frame(1'b0, 1'b0);
    vbat_ok = 1'b0;
    cyc(6);
    chk(power_output_channels, 5'h00);
    chk(serial_link_fault_flag, 1'b1);
    vbat_ok = 1'b1;
    frame(1'b1, 1'b0);
    vcc_ok = 1'b0;
    cyc(10);
    chk(serial_link_fault_flag, 1'b1);
    vbat_ok = 1'b0;
    cyc(10);
    chk(fail_mode, 1'b0);
    chk(serial_link_fault_flag, 1'b0);
    vcc_ok = 1'b1;
    cyc(4);
    vbat_ok = 1'b1;
    wd = 1'b0;
    cyc(4);
    frame(1'b1, 1'b0);
    chk(rx_word, w);
    test_done;
  end
endmodule // testbench
`default_nettype wire
